// ==== verilog/reset_boot_loader_defs.vh ====
// Purpose: constants of the reset-time boot loader
// Assumes: included by its bare name
// Notes: definitions only
`ifndef RESET_BOOT_LOADER_DEFS_VH
`define RESET_BOOT_LOADER_DEFS_VH

// ----------------------------------------
// boot mode codes
// ----------------------------------------
`define RBL_MODE_EXT_EXEC 3'h0
`define RBL_MODE_FLASH8 3'h1
`define RBL_MODE_SPI_A8 3'h2
`define RBL_MODE_SPI_A16 3'h3

// ----------------------------------------
// addresses
// ----------------------------------------
`define RBL_EXT_EXEC_ADDR 32'h02000000
`define RBL_L2_EXEC_ADDR 32'h00000000
`define RBL_L2_BASE 18'h00000
`define RBL_FLASH_BASE 24'h000000

// ----------------------------------------
// flash bank timing in clock cycles
// ----------------------------------------
`define RBL_FL_SETUP 4'h4
`define RBL_FL_ACCESS 4'hf
`define RBL_FL_HOLD 4'h3
`define RBL_FL_SAMPLE 4'h1

// ----------------------------------------
// serial boot
// ----------------------------------------
`define RBL_SPI_READ_CMD 8'h03
`define RBL_SPI_START_ADDR 8'h00
`define RBL_SPI_HALF 3'h4
`define RBL_HDR_BYTES 3'h4
`define RBL_SYNC_WAIT 2'h3

`endif

// ==== verilog/reset_boot_loader.v ====
// Purpose: reset-time boot sequencer that loads second level sram or jumps to external code
// Assumes: clk_sys 200 MHz, reset_n async active low, soft_reset a one-cycle pulse on clk_sys
// Notes: how it works
// How it works
// - capture mode pins at power-on and soft reset
// - decode 000 exec, 001 flash, 010/011 serial
// - direct mode jumps to 0x2000000, 16-bit packing
// - flash via bank 4, setup 4 access 15 hold 3
// - serial boot selects one eeprom by flag 10
// - 8-bit serial boot: read command, address 0x00
// - 16-bit serial boot: read command, address 0x0000
// - four-byte length first, then that many bytes
// - after load jump to start of sram
// - bypass bit skips load on soft reset
`include "reset_boot_loader_defs.vh"
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// byte fifo
// ----------------------------------------
module boot_byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // clock and reset
    input wire clk_sys,
    input wire reset_n,
    input wire flush,
    // fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data = mem[rd_q];

    always @(posedge clk_sys) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else if (flush) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

// ----------------------------------------
// boot sequencer
// ----------------------------------------
module reset_boot_loader (
    // clock and reset
    input wire clk_sys,
    input wire reset_n,
    // software reset and reset configuration bit 4
    input wire soft_reset,
    input wire reset_cfg_bypass,
    // boot mode pins
    input wire [2:0] boot_mode_select,
    // parallel flash on bank 4
    output reg [23:0] flash_addr,
    output reg flash_bank4_sel_n,
    output reg flash_rd_n,
    input wire [7:0] flash_data,
    // serial boot port
    output reg spi_sck,
    output reg spi_mosi,
    input wire spi_miso,
    output reg serial_boot_chip_select_flag_n,
    // second level sram write port
    output reg [17:0] sram_addr,
    output reg [7:0] sram_wdata,
    output reg sram_we,
    input wire sram_ready,
    // execution hand-off
    output reg exec_start,
    output reg [31:0] exec_addr,
    output reg exec_pack16,
    output reg boot_busy,
    output reg boot_error
);
    localparam ST_SAMPLE = 4'h0;
    localparam ST_NEXT = 4'h1;
    localparam ST_FL_SETUP = 4'h2;
    localparam ST_FL_ACC = 4'h3;
    localparam ST_FL_HOLD = 4'h4;
    localparam ST_SPI = 4'h5;
    localparam ST_DRAIN = 4'h6;
    localparam ST_DONE = 4'h7;
    localparam ST_ERROR = 4'h8;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    reg [2:0] mode_m_q;
    reg [2:0] mode_s_q;
    reg [7:0] fdat_m_q;
    reg [7:0] fdat_s_q;
    reg miso_m_q;
    reg miso_s_q;

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mode_m_q <= 3'h0;
            mode_s_q <= 3'h0;
            fdat_m_q <= 8'h00;
            fdat_s_q <= 8'h00;
            miso_m_q <= 1'b0;
            miso_s_q <= 1'b0;
        end else begin
            mode_m_q <= boot_mode_select;
            mode_s_q <= mode_m_q;
            fdat_m_q <= flash_data;
            fdat_s_q <= fdat_m_q;
            miso_m_q <= spi_miso;
            miso_s_q <= miso_m_q;
        end
    end

    // ----------------------------------------
    // serial byte engine, mode 0, msb first
    // ----------------------------------------
    reg [2:0] div_q;
    reg tick_q;
    reg spi_go_q;
    reg [7:0] spi_tx_q;
    reg spi_busy_q;
    reg [2:0] spi_bit_q;
    reg [7:0] spi_sh_q;
    reg spi_done_q;

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            div_q <= 3'h0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (div_q == `RBL_SPI_HALF - 3'h1);
            div_q <= (div_q == `RBL_SPI_HALF - 3'h1) ? 3'h0 : div_q + 3'h1;
        end
    end

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            spi_busy_q <= 1'b0;
            spi_bit_q <= 3'h0;
            spi_sh_q <= 8'h00;
            spi_done_q <= 1'b0;
            spi_sck <= 1'b0;
            spi_mosi <= 1'b0;
        end else begin
            spi_done_q <= 1'b0;
            if (soft_reset) begin
                spi_busy_q <= 1'b0;
                spi_sck <= 1'b0;
            end else if (spi_go_q) begin
                spi_busy_q <= 1'b1;
                spi_bit_q <= 3'h0;
                spi_sh_q <= spi_tx_q;
                spi_mosi <= spi_tx_q[7];
                spi_sck <= 1'b0;
            end else if (spi_busy_q && tick_q) begin
                if (!spi_sck) begin
                    spi_sck <= 1'b1;
                    spi_sh_q <= {spi_sh_q[6:0], miso_s_q};
                end else begin
                    spi_sck <= 1'b0;
                    spi_bit_q <= spi_bit_q + 3'h1;
                    spi_mosi <= spi_sh_q[7];
                    if (spi_bit_q == 3'h7) begin
                        spi_busy_q <= 1'b0;
                        spi_done_q <= 1'b1;
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // byte fifo towards sram
    // ----------------------------------------
    reg push_q;
    reg [7:0] push_data_q;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [7:0] fifo_out_data;
    wire fifo_out_ready = !sram_we || sram_ready;

    boot_byte_fifo #(.WIDTH(8), .DEPTH(16), .AW(4)) u_fifo (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .flush(soft_reset),
        .in_valid(push_q),
        .in_ready(fifo_in_ready),
        .in_data(push_data_q),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    reg [3:0] state_q;
    reg [1:0] wait_q;
    reg soft_q;
    reg bypass_q;
    reg [2:0] mode_q;
    reg [3:0] cyc_q;
    reg [1:0] phase_q;
    reg [2:0] hdr_q;
    reg [31:0] len_q;
    reg [31:0] loaded_q;
    reg [31:0] written_q;
    reg got;
    reg [7:0] got_byte;
    wire [1:0] addr_bytes = (mode_q == `RBL_MODE_SPI_A16) ? 2'h2 : 2'h1;

    // a fetched byte, from flash or from the serial data phase
    always @* begin
        got = 1'b0;
        got_byte = spi_sh_q;
        if (state_q == ST_FL_HOLD && cyc_q == `RBL_FL_SAMPLE) begin
            got = 1'b1;
            got_byte = fdat_s_q;
        end else if (state_q == ST_SPI && spi_done_q && phase_q > addr_bytes) begin
            got = 1'b1;
        end
    end

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_SAMPLE;
            wait_q <= 2'h0;
            soft_q <= 1'b0;
            bypass_q <= 1'b0;
            mode_q <= 3'h0;
            cyc_q <= 4'h0;
            phase_q <= 2'h0;
            hdr_q <= 3'h0;
            len_q <= 32'h00000000;
            loaded_q <= 32'h00000000;
            push_q <= 1'b0;
            push_data_q <= 8'h00;
            spi_go_q <= 1'b0;
            spi_tx_q <= 8'h00;
            flash_addr <= `RBL_FLASH_BASE;
            flash_bank4_sel_n <= 1'b1;
            flash_rd_n <= 1'b1;
            serial_boot_chip_select_flag_n <= 1'b1;
            exec_start <= 1'b0;
            exec_addr <= 32'h00000000;
            exec_pack16 <= 1'b0;
            boot_busy <= 1'b1;
            boot_error <= 1'b0;
        end else if (soft_reset) begin
            state_q <= ST_SAMPLE;
            wait_q <= 2'h0;
            soft_q <= 1'b1;
            bypass_q <= reset_cfg_bypass;
            hdr_q <= 3'h0;
            len_q <= 32'h00000000;
            loaded_q <= 32'h00000000;
            push_q <= 1'b0;
            spi_go_q <= 1'b0;
            phase_q <= 2'h0;
            flash_addr <= `RBL_FLASH_BASE;
            flash_bank4_sel_n <= 1'b1;
            flash_rd_n <= 1'b1;
            serial_boot_chip_select_flag_n <= 1'b1;
            exec_start <= 1'b0;
            exec_pack16 <= 1'b0;
            boot_busy <= 1'b1;
            boot_error <= 1'b0;
        end else begin
            push_q <= 1'b0;
            spi_go_q <= 1'b0;
            exec_start <= 1'b0;
            if (got) begin
                if (hdr_q != `RBL_HDR_BYTES) begin
                    len_q <= {got_byte, len_q[31:8]};
                    hdr_q <= hdr_q + 3'h1;
                end else begin
                    push_q <= 1'b1;
                    push_data_q <= got_byte;
                    loaded_q <= loaded_q + 32'h1;
                end
            end
            case (state_q)
                ST_SAMPLE: begin
                    wait_q <= wait_q + 2'h1;
                    if (wait_q == `RBL_SYNC_WAIT) begin
                        mode_q <= mode_s_q;
                        if (soft_q && bypass_q) begin
                            state_q <= ST_DONE;
                            exec_addr <= `RBL_L2_EXEC_ADDR;
                            exec_start <= 1'b1;
                            boot_busy <= 1'b0;
                        end else if (mode_s_q == `RBL_MODE_EXT_EXEC) begin
                            state_q <= ST_DONE;
                            exec_addr <= `RBL_EXT_EXEC_ADDR;
                            exec_pack16 <= 1'b1;
                            exec_start <= 1'b1;
                            boot_busy <= 1'b0;
                        end else if (mode_s_q == `RBL_MODE_FLASH8 ||
                                     mode_s_q == `RBL_MODE_SPI_A8 ||
                                     mode_s_q == `RBL_MODE_SPI_A16) begin
                            state_q <= ST_NEXT;
                        end else begin
                            state_q <= ST_ERROR;
                        end
                    end
                end
                ST_NEXT: begin
                    if (push_q) begin
                        state_q <= ST_NEXT;
                    end else if (hdr_q == `RBL_HDR_BYTES && loaded_q == len_q) begin
                        state_q <= ST_DRAIN;
                        serial_boot_chip_select_flag_n <= 1'b1;
                    end else if (fifo_in_ready) begin
                        cyc_q <= 4'h0;
                        if (mode_q == `RBL_MODE_FLASH8) begin
                            state_q <= ST_FL_SETUP;
                            flash_bank4_sel_n <= 1'b0;
                        end else begin
                            state_q <= ST_SPI;
                            serial_boot_chip_select_flag_n <= 1'b0;
                            spi_go_q <= 1'b1;
                            if (phase_q == 2'h0) begin
                                spi_tx_q <= `RBL_SPI_READ_CMD;
                            end else begin
                                spi_tx_q <= `RBL_SPI_START_ADDR;
                            end
                        end
                    end
                end
                ST_FL_SETUP: begin
                    cyc_q <= cyc_q + 4'h1;
                    if (cyc_q == `RBL_FL_SETUP - 4'h1) begin
                        cyc_q <= 4'h0;
                        flash_rd_n <= 1'b0;
                        state_q <= ST_FL_ACC;
                    end
                end
                ST_FL_ACC: begin
                    cyc_q <= cyc_q + 4'h1;
                    if (cyc_q == `RBL_FL_ACCESS - 4'h1) begin
                        cyc_q <= 4'h0;
                        flash_rd_n <= 1'b1;
                        state_q <= ST_FL_HOLD;
                    end
                end
                ST_FL_HOLD: begin
                    cyc_q <= cyc_q + 4'h1;
                    if (cyc_q == `RBL_FL_HOLD - 4'h1) begin
                        flash_bank4_sel_n <= 1'b1;
                        flash_addr <= flash_addr + 24'h1;
                        state_q <= ST_NEXT;
                    end
                end
                ST_SPI: begin
                    if (spi_done_q) begin
                        if (phase_q <= addr_bytes) begin
                            phase_q <= phase_q + 2'h1;
                        end
                        state_q <= ST_NEXT;
                    end
                end
                ST_DRAIN: begin
                    if (written_q == len_q && !sram_we) begin
                        state_q <= ST_DONE;
                        exec_addr <= `RBL_L2_EXEC_ADDR;
                        exec_start <= 1'b1;
                        boot_busy <= 1'b0;
                    end
                end
                ST_DONE: begin
                    state_q <= ST_DONE;
                end
                ST_ERROR: begin
                    boot_error <= 1'b1;
                    boot_busy <= 1'b0;
                end
                default: begin
                    state_q <= ST_ERROR;
                end
            endcase
        end
    end

    // ----------------------------------------
    // sram writer, ascending from the base
    // ----------------------------------------
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sram_we <= 1'b0;
            sram_addr <= `RBL_L2_BASE;
            sram_wdata <= 8'h00;
            written_q <= 32'h00000000;
        end else if (soft_reset) begin
            sram_we <= 1'b0;
            sram_addr <= `RBL_L2_BASE;
            written_q <= 32'h00000000;
        end else begin
            if (sram_we && sram_ready) begin
                written_q <= written_q + 32'h1;
                sram_addr <= sram_addr + 18'h1;
            end
            if (fifo_out_ready) begin
                sram_we <= fifo_out_valid;
                if (fifo_out_valid) begin
                    sram_wdata <= fifo_out_data;
                end
            end
        end
    end
endmodule

`default_nettype wire

// ==== verification/reset_boot_loader_monitor.sv ====
// Purpose: port checker for the boot sequencer
// Assumes: one clock domain, reset_n async active low
// Notes: attached by bind at the foot of this file
`include "reset_boot_loader_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module reset_boot_loader_monitor (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // flash
    input wire logic [23:0] flash_addr,
    input wire logic flash_bank4_sel_n,
    input wire logic flash_rd_n,
    // serial
    input wire logic spi_sck,
    input wire logic serial_boot_chip_select_flag_n,
    // sram
    input wire logic [17:0] sram_addr,
    input wire logic [7:0] sram_wdata,
    input wire logic sram_we,
    input wire logic sram_ready,
    // hand-off
    input wire logic exec_start,
    input wire logic [31:0] exec_addr,
    input wire logic exec_pack16,
    input wire logic boot_error
);
    logic [4:0] rd_cnt_q;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // ----------------------------------------
    // length of the flash read strobe
    // ----------------------------------------
    always @(posedge clk_sys or negedge reset_n) begin
        rd_cnt_q <= (!reset_n || flash_rd_n) ? 5'h00 : rd_cnt_q + 5'h01;
    end
    a_direct_exec_addr: assert property (exec_start && exec_pack16 |->
        exec_addr == `RBL_EXT_EXEC_ADDR) else $error("direct start address wrong");
    a_load_exec_addr: assert property (exec_start && !exec_pack16 |->
        exec_addr == `RBL_L2_EXEC_ADDR) else $error("load start address wrong");
    a_exec_one_cycle: assert property (exec_start |=> !exec_start)
        else $error("start pulse too long");
    a_one_select: assert property (flash_bank4_sel_n || serial_boot_chip_select_flag_n)
        else $error("both boot sources selected");
    a_sck_in_frame: assert property (spi_sck |-> !serial_boot_chip_select_flag_n)
        else $error("serial clock without select");
    a_flash_setup: assert property ($fell(flash_bank4_sel_n) |->
        (flash_rd_n && !flash_bank4_sel_n) [*4] ##1 !flash_rd_n) else $error("setup not 4");
    a_flash_access: assert property ($rose(flash_rd_n) |-> rd_cnt_q == 5'h0f)
        else $error("access not 15");
    a_flash_hold: assert property ($rose(flash_rd_n) |->
        !flash_bank4_sel_n [*3] ##1 flash_bank4_sel_n) else $error("hold not 3");
    a_flash_addr_steady: assert property (!flash_bank4_sel_n && $past(!flash_bank4_sel_n) |->
        $stable(flash_addr)) else $error("flash address moved");
    a_sram_ascend: assert property (sram_we && sram_ready |=>
        sram_addr == $past(sram_addr) + 18'h1) else $error("sram address not ascending");
    a_sram_hold: assert property (sram_we && !sram_ready |=>
        sram_we && $stable(sram_addr) && $stable(sram_wdata)) else $error("write dropped");
    a_error_quiet: assert property (boot_error |-> flash_bank4_sel_n &&
        serial_boot_chip_select_flag_n && !sram_we) else $error("activity after bad mode");
    c_direct: cover property (exec_start && exec_pack16);
    c_stall: cover property (sram_we && !sram_ready);
    c_error: cover property (boot_error);
endmodule
bind reset_boot_loader reset_boot_loader_monitor i_mon (.clk_sys, .reset_n, .flash_addr,
    .flash_bank4_sel_n, .flash_rd_n, .spi_sck, .serial_boot_chip_select_flag_n, .sram_addr,
    .sram_wdata, .sram_we, .sram_ready, .exec_start, .exec_addr, .exec_pack16, .boot_error);
`default_nettype wire

// ==== verification/boot_source_model.sv ====
// Purpose: parallel flash and serial eeprom holding the boot image
// Assumes: image written into mem by the bench
// Notes: released lines show a changing pattern
`include "reset_boot_loader_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module boot_source_model (
    // clock for the idle pattern
    input wire logic clk_sys,
    // flash side
    input wire logic [23:0] flash_addr,
    input wire logic flash_bank4_sel_n,
    output logic [7:0] flash_data,
    // serial side
    input wire logic spi_sck,
    input wire logic spi_mosi,
    input wire logic serial_boot_chip_select_flag_n,
    output logic spi_miso,
    input wire logic [1:0] addr_bytes,
    output int bad_cmds
);
    logic [7:0] mem [0:63];
    logic [7:0] cmd_q;
    int nbit;
    int k;
    // ----------------------------------------
    // flash answers only while selected
    // ----------------------------------------
    assign flash_data = flash_bank4_sel_n ? ~mem[flash_addr[5:0]] : mem[flash_addr[5:0]];
    initial begin
        nbit = 0;
        bad_cmds = 0;
        spi_miso = 1'b0;
    end
    always @(negedge serial_boot_chip_select_flag_n) nbit = 0;
    always @(posedge clk_sys) if (serial_boot_chip_select_flag_n) spi_miso <= ~spi_miso;
    // command then 1 or 2 zero address bytes, taken at sck rise
    always @(posedge spi_sck) begin
        cmd_q = {cmd_q[6:0], spi_mosi};
        nbit = nbit + 1;
        if (nbit == 8 && cmd_q !== `RBL_SPI_READ_CMD) bad_cmds++;
        if (nbit > 8 && nbit <= 8 + 8 * addr_bytes && spi_mosi !== 1'b0) bad_cmds++;
    end
    // data msb first from byte 0, shifted out at sck fall
    always @(negedge spi_sck) begin
        k = nbit - 8 - 8 * addr_bytes;
        if (k >= 0) spi_miso = mem[k >> 3][7 - (k & 7)];
    end
endmodule
`default_nettype wire

// ==== verification/reset_boot_loader_tb.sv ====
// Purpose: self-checking bench for the boot sequencer
// Assumes: 200 MHz clk_sys, inputs driven 1 ns after the rising edge
// Notes: writes and starts are noted in queues and checked by a watcher
`include "reset_boot_loader_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module reset_boot_loader_tb;
    logic clk_sys, reset_n, soft_reset, reset_cfg_bypass, sram_ready, stall;
    logic [2:0] boot_mode_select;
    logic [1:0] addr_bytes;
    logic [7:0] rdy_q, pay_q;
    logic [25:0] wr_q [$];
    logic [32:0] ex_q [$];
    wire [23:0] flash_addr;
    wire [7:0] flash_data, sram_wdata;
    wire [17:0] sram_addr;
    wire [31:0] exec_addr;
    wire flash_bank4_sel_n, flash_rd_n, spi_sck, spi_mosi, spi_miso, cs_n;
    wire sram_we, exec_start, exec_pack16, boot_busy, boot_error;
    int bad_cmds, n_errors, checks, cyc, m;
    reset_boot_loader i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .soft_reset(soft_reset),
        .reset_cfg_bypass(reset_cfg_bypass), .boot_mode_select(boot_mode_select),
        .flash_addr(flash_addr), .flash_bank4_sel_n(flash_bank4_sel_n), .flash_rd_n(flash_rd_n),
        .flash_data(flash_data), .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .serial_boot_chip_select_flag_n(cs_n), .sram_addr(sram_addr), .sram_wdata(sram_wdata),
        .sram_we(sram_we), .sram_ready(sram_ready), .exec_start(exec_start),
        .exec_addr(exec_addr), .exec_pack16(exec_pack16), .boot_busy(boot_busy),
        .boot_error(boot_error));
    boot_source_model i_src (.clk_sys(clk_sys), .flash_addr(flash_addr),
        .flash_bank4_sel_n(flash_bank4_sel_n), .flash_data(flash_data), .spi_sck(spi_sck),
        .spi_mosi(spi_mosi), .serial_boot_chip_select_flag_n(cs_n), .spi_miso(spi_miso),
        .addr_bytes(addr_bytes), .bad_cmds(bad_cmds));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk_wr(input logic [25:0] exp, input logic [25:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH sram write exp %h got %h", exp, got);
        end
    endtask
    task automatic chk_ex(input logic [32:0] exp, input logic [32:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH start exp %h got %h", exp, got);
        end
    endtask
    task automatic chk_flag(input string name, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s exp %b got %b", name, exp, got);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // one boot: image, expectations, reset, wait for the end
    task automatic boot(input logic [2:0] mode, input bit po, input logic byp, input int len);
        int i;
        int w;
        bit ld;
        ld = mode != 3'h0 && mode < 3'h4 && (po || !byp);
        boot_mode_select = mode;
        reset_cfg_bypass = byp;
        addr_bytes = (mode == `RBL_MODE_SPI_A16) ? 2'h2 : 2'h1;
        for (i = 0; i < 4; i++) i_src.mem[i] = len >> (8 * i);
        for (i = 0; i < len; i++) begin
            pay_q = lfsr_next(pay_q);
            i_src.mem[i + 4] = pay_q;
            if (ld) wr_q.push_back({i[17:0], pay_q});
        end
        if (mode < 3'h4) ex_q.push_back((mode == 3'h0) ? {1'b1, `RBL_EXT_EXEC_ADDR} :
            {1'b0, `RBL_L2_EXEC_ADDR});
        if (po) begin
            reset_n = 1'b0;
            tick(3);
            reset_n = 1'b1;
        end else begin
            soft_reset = 1'b1;
            tick(1);
            soft_reset = 1'b0;
        end
        tick(2);
        if (ld) begin
            tick(8);
            boot_mode_select = 3'h7;
            stall = len > 16;
            tick(600);
            stall = 1'b0;
        end
        w = 0;
        while (boot_busy === 1'b1 && w < 5000) begin
            tick(1);
            w++;
        end
        tick(3);
        chk_flag("error", mode >= 3'h4, boot_error);
        chk_flag("pending", 1'b1, wr_q.size() == 0 && ex_q.size() == 0);
        chk_flag("command", 1'b1, bad_cmds == 0);
        $display("test mode %h soft %b bypass %b len %0d done", mode, !po, byp, len);
    endtask
    // ----------------------------------------
    // clock, ready, watcher, timeout
    // ----------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        #1 rdy_q = lfsr_next(rdy_q);
        sram_ready = (rdy_q[1:0] != 2'h0) && !stall;
    end
    always @(posedge clk_sys) begin
        if ((sram_we & sram_ready) === 1'b1)
            chk_wr(wr_q.size() ? wr_q.pop_front() : 26'hx, {sram_addr, sram_wdata});
        if (exec_start === 1'b1)
            chk_ex(ex_q.size() ? ex_q.pop_front() : 33'hx, {exec_pack16, exec_addr});
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end
    initial begin
        reset_n = 1'b0;
        soft_reset = 1'b0;
        reset_cfg_bypass = 1'b0;
        boot_mode_select = 3'h0;
        addr_bytes = 2'h1;
        sram_ready = 1'b0;
        stall = 1'b0;
        rdy_q = 8'h19;
        pay_q = 8'h19;
        tick(3);
        boot(`RBL_MODE_EXT_EXEC, 1, 1'b0, 0);
        boot(`RBL_MODE_FLASH8, 1, 1'b1, 20);
        boot(`RBL_MODE_SPI_A8, 0, 1'b0, 3);
        boot(`RBL_MODE_SPI_A16, 0, 1'b0, 2);
        boot(`RBL_MODE_FLASH8, 0, 1'b1, 4);
        boot(`RBL_MODE_FLASH8, 0, 1'b0, 0);
        for (m = 4; m < 8; m++) boot(m[2:0], 1, 1'b0, 0);
        report_and_stop();
    end
endmodule
`default_nettype wire
